/* logic/sli_defines.vh */
`ifndef SLI_DEFINES_VH
`define SLI_DEFINES_VH

// ****************************************************************
// Clock and timing figures
// ****************************************************************
`define SLI_CLK_HZ          20000000
// Blink periods in milliseconds: 0.4 Hz is 2500 ms, 1.2 Hz is about 833 ms.
`define SLI_PREOP_MS        2500
`define SLI_SAFEOP_MS       833
`define SLI_FLICKER_MS      50
`define SLI_SHORT_MS        200
`define SLI_LONG_MS         600
`define SLI_GAP_MS          200
`define SLI_POWERUP_S       15
`define SLI_ACT_HOLD_MS     50
`define SLI_MS_CYCLES       (`SLI_CLK_HZ / 1000)

// ****************************************************************
// Fieldbus state codes
// ****************************************************************
`define SLI_ST_INIT         3'h1
`define SLI_ST_PREOP        3'h2
`define SLI_ST_BOOT         3'h3
`define SLI_ST_SAFEOP       3'h4
`define SLI_ST_OP           3'h5

// ****************************************************************
// Module indication codes
// ****************************************************************
`define SLI_IND_NORMAL      3'h0
`define SLI_IND_COMERR      3'h1
`define SLI_IND_CFGERR      3'h2
`define SLI_IND_DOWNLOAD    3'h3
`define SLI_IND_ACTIVATE    3'h4

`endif

/* logic/sli_tick_gen.v */
`timescale 1ns/1ps
`include "sli_defines.vh"

// ****************************************************************
// One-millisecond tick prescaler
// ****************************************************************
module sli_tick_gen
#(
  parameter DIV = `SLI_MS_CYCLES
)
(
  input  wire clk,
  input  wire rst_n,
  output reg  tick_ms
);

  reg [15:0] cnt_r;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r   <= 16'h0000;
      tick_ms <= 1'b0;
    end
    else if (cnt_r == DIV[15:0] - 16'h0001)
    begin
      cnt_r   <= 16'h0000;
      tick_ms <= 1'b1;
    end
    else
    begin
      cnt_r   <= cnt_r + 16'h0001;
      tick_ms <= 1'b0;
    end
  end

endmodule

/* logic/sli_activity.v */
`timescale 1ns/1ps
`include "sli_defines.vh"

// ****************************************************************
// Activity stretcher: one pulse keeps the LED lit for HOLD ticks
// ****************************************************************
module sli_activity
#(
  parameter HOLD = `SLI_ACT_HOLD_MS
)
(
  input  wire clk,
  input  wire rst_n,
  input  wire tick_ms,
  input  wire event_in,
  output reg  led
);

  reg [7:0] hold_r;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hold_r <= 8'h00;
      led    <= 1'b0;
    end
    else
    begin
      // A new event wins over the countdown so bursts keep the LED lit.
      if (event_in)
        hold_r <= HOLD[7:0];
      else if (tick_ms && hold_r != 8'h00)
        hold_r <= hold_r - 8'h01;
      led <= event_in || (hold_r != 8'h00);
    end
  end

endmodule

/* logic/sli_status_led.v */
`timescale 1ns/1ps
`include "sli_defines.vh"

// Overview of operation
// - Top LED follows bus state when not a module: off, 0.4 Hz, 1.2 Hz, flicker, steady on.
// - Upstream and downstream activity each light their own LED; backplane activity lights the bottom LED only when not a module.
// - When not a module, top LED lit steadily only after roughly 15 s power-up completes.
// - Module in normal operation holds all three in-line LEDs steadily on.
// - SOS shown when hot-swap enabled and socket memory holds no configuration.
// - SOS shown when stored module type differs from inserted module type.
// - Reconfiguration writes new configuration into socket memory, clearing mismatch.
// - Firmware download shows its own informational flashing pattern.
// - Activation flashes LEDs top to bottom, then requests module restart.
// - Patterns use a brief flash and a longer flash.
// - Transmission error drives the top LED with irregular flashing.
module sli_status_led
#(
  parameter POWERUP_MS = `SLI_POWERUP_S * 1000,
  parameter MS_DIV     = `SLI_MS_CYCLES,
  parameter TYPE_W     = 8
)
(
  input  wire              REF_CLK,
  input  wire              RSTN,
  input  wire              IS_MODULE,
  input  wire [2:0]        BUS_STATE,
  input  wire              UP_ACT,
  input  wire              DOWN_ACT,
  input  wire              LINK_ACT,
  input  wire              COMM_ERR,
  input  wire              HOT_SWAP_EN,
  input  wire              CFG_STORED,
  input  wire [TYPE_W-1:0] CFG_TYPE,
  input  wire [TYPE_W-1:0] MODULE_TYPE,
  input  wire              RECONFIG_DONE,
  input  wire              FW_DOWNLOAD,
  input  wire              FW_ACTIVATE,
  input  wire              FW_RECONF_DONE,
  output reg               UPSTREAM_PORT_LED,
  output reg               DOWNSTREAM_PORT_LED,
  output reg               TOP_STATUS_LED,
  output reg               MIDDLE_STATUS_LED,
  output reg               BOTTOM_LINK_LED,
  output reg               CFG_WRITE,
  output reg  [TYPE_W-1:0] CFG_WRITE_TYPE,
  output reg               MODULE_RESTART
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  localparam NSYNC = 11;
  wire [NSYNC-1:0] raw_in = {IS_MODULE, UP_ACT, DOWN_ACT, LINK_ACT, COMM_ERR,
                             HOT_SWAP_EN, CFG_STORED, RECONFIG_DONE,
                             FW_DOWNLOAD, FW_ACTIVATE, FW_RECONF_DONE};
  reg  [NSYNC-1:0] s1_r;
  reg  [NSYNC-1:0] s2_r;
  reg  [2:0]       st1_r;
  reg  [2:0]       st2_r;
  reg  [TYPE_W-1:0] ct1_r;
  reg  [TYPE_W-1:0] ct2_r;
  reg  [TYPE_W-1:0] mt1_r;
  reg  [TYPE_W-1:0] mt2_r;

  always @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      s1_r  <= {NSYNC{1'b0}};
      s2_r  <= {NSYNC{1'b0}};
      st1_r <= 3'h0;
      st2_r <= 3'h0;
      ct1_r <= {TYPE_W{1'b0}};
      ct2_r <= {TYPE_W{1'b0}};
      mt1_r <= {TYPE_W{1'b0}};
      mt2_r <= {TYPE_W{1'b0}};
    end
    else
    begin
      s1_r  <= raw_in;
      s2_r  <= s1_r;
      st1_r <= BUS_STATE;
      st2_r <= st1_r;
      ct1_r <= CFG_TYPE;
      ct2_r <= ct1_r;
      mt1_r <= MODULE_TYPE;
      mt2_r <= mt1_r;
    end
  end

  wire is_mod   = s2_r[10];
  wire up_a     = s2_r[9];
  wire down_a   = s2_r[8];
  wire link_a   = s2_r[7];
  wire com_err  = s2_r[6];
  wire hs_en    = s2_r[5];
  wire cfg_st   = s2_r[4];
  wire reconf   = s2_r[3];
  wire fw_dl    = s2_r[2];
  wire fw_act   = s2_r[1];
  wire fw_done  = s2_r[0];

  // ****************************************************************
  // Prescaler and activity LEDs
  // ****************************************************************
  wire       tick;
  wire [2:0] act_evt = {up_a, down_a, link_a};
  wire [2:0] act_lit;
  genvar     gi;

  sli_tick_gen #(.DIV(MS_DIV)) u_tick
  (
    .clk     (REF_CLK),
    .rst_n   (RSTN),
    .tick_ms (tick)
  );

  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_act
      sli_activity u_act (.clk(REF_CLK), .rst_n(RSTN), .tick_ms(tick),
                          .event_in(act_evt[gi]), .led(act_lit[gi]));
    end
  endgenerate

  // ****************************************************************
  // Power-up timer and free-running blink phases
  // ****************************************************************
  reg [15:0] pwr_r;
  reg [11:0] preop_r;
  reg [9:0]  safe_r;
  reg [5:0]  flick_r;
  reg [10:0] seq_r;
  wire       pwr_done = (pwr_r == POWERUP_MS[15:0]);

  always @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      pwr_r   <= 16'h0000;
      preop_r <= 12'h000;
      safe_r  <= 10'h000;
      flick_r <= 6'h00;
    end
    else if (tick)
    begin
      if (!pwr_done)
        pwr_r <= pwr_r + 16'h0001;
      preop_r <= (preop_r == `SLI_PREOP_MS - 1) ? 12'h000 : preop_r + 12'h001;
      safe_r  <= (safe_r == `SLI_SAFEOP_MS - 1) ? 10'h000 : safe_r + 10'h001;
      flick_r <= (flick_r == `SLI_FLICKER_MS - 1) ? 6'h00 : flick_r + 6'h01;
    end
  end

  wire preop_on = (preop_r < `SLI_PREOP_MS / 2);
  wire safe_on  = (safe_r < `SLI_SAFEOP_MS / 2);
  wire flick_on = (flick_r < `SLI_FLICKER_MS / 2);

  // ****************************************************************
  // Module indication selection
  // ****************************************************************
  wire cfg_err = (hs_en && !cfg_st) ||
                 (cfg_st && ct2_r != mt2_r);
  reg  [2:0] ind;

  always @*
  begin
    if (fw_act)
      ind = `SLI_IND_ACTIVATE;
    else if (fw_dl)
      ind = `SLI_IND_DOWNLOAD;
    else if (cfg_err)
      ind = `SLI_IND_CFGERR;
    else if (com_err)
      ind = `SLI_IND_COMERR;
    else
      ind = `SLI_IND_NORMAL;
  end

  // ****************************************************************
  // Pulse sequencer: SOS, download and activation patterns
  // ****************************************************************
  // SOS is 9 marks: short, short, short, long, long, long, short x3.
  localparam SQ_IDLE = 2'h0;
  localparam SQ_ON   = 2'h1;
  localparam SQ_OFF  = 2'h2;

  reg [1:0]  sq_r;
  reg [3:0]  mark_r;
  reg [2:0]  ind_r;
  reg [3:0]  lfsr_r;
  reg        pulse_on;
  reg [10:0] mark_len;

  always @*
  begin
    mark_len = 11'd`SLI_SHORT_MS;
    case (ind_r)
      `SLI_IND_CFGERR:
        if (mark_r >= 4'h3 && mark_r <= 4'h5)
          mark_len = 11'd`SLI_LONG_MS;
      `SLI_IND_DOWNLOAD:
        if (mark_r[0])
          mark_len = 11'd`SLI_LONG_MS;
      `SLI_IND_COMERR:
        mark_len = {5'h00, lfsr_r, 2'h0} + 11'h028;
      default:
        mark_len = 11'd`SLI_SHORT_MS;
    endcase
  end

  always @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      sq_r     <= SQ_IDLE;
      mark_r   <= 4'h0;
      seq_r    <= 11'h000;
      ind_r    <= `SLI_IND_NORMAL;
      lfsr_r   <= 4'h1;
      pulse_on <= 1'b0;
    end
    else if (ind != ind_r)
    begin
      // A change of indication restarts the pattern from its first mark.
      ind_r    <= ind;
      sq_r     <= (ind == `SLI_IND_NORMAL) ? SQ_IDLE : SQ_ON;
      mark_r   <= 4'h0;
      seq_r    <= 11'h000;
      pulse_on <= (ind != `SLI_IND_NORMAL);
    end
    else if (tick)
    begin
      case (sq_r)
        SQ_ON:
          if (seq_r >= mark_len - 11'h001)
          begin
            sq_r     <= SQ_OFF;
            seq_r    <= 11'h000;
            pulse_on <= 1'b0;
            lfsr_r   <= {lfsr_r[2:0], lfsr_r[3] ^ lfsr_r[2]};
          end
          else
            seq_r <= seq_r + 11'h001;
        SQ_OFF:
          if (seq_r >= ((mark_r == 4'h8 && ind_r == `SLI_IND_CFGERR) ?
                        11'd`SLI_LONG_MS * 2 : 11'd`SLI_GAP_MS))
          begin
            sq_r     <= SQ_ON;
            seq_r    <= 11'h000;
            pulse_on <= 1'b1;
            mark_r   <= (mark_r == 4'h8) ? 4'h0 : mark_r + 4'h1;
          end
          else
            seq_r <= seq_r + 11'h001;
        default:
          sq_r <= SQ_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Registered LED outputs and socket/restart handshakes
  // ****************************************************************
  // Activation lights one LED per mark, top to bottom, so the mark number modulo 3 picks it.
  wire [3:0] act_led = mark_r % 4'h3;

  always @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      UPSTREAM_PORT_LED   <= 1'b0;
      DOWNSTREAM_PORT_LED <= 1'b0;
      TOP_STATUS_LED      <= 1'b0;
      MIDDLE_STATUS_LED   <= 1'b0;
      BOTTOM_LINK_LED     <= 1'b0;
      CFG_WRITE           <= 1'b0;
      CFG_WRITE_TYPE      <= {TYPE_W{1'b0}};
      MODULE_RESTART      <= 1'b0;
    end
    else
    begin
      UPSTREAM_PORT_LED   <= act_lit[2];
      DOWNSTREAM_PORT_LED <= act_lit[1];
      CFG_WRITE           <= reconf && !CFG_WRITE;
      CFG_WRITE_TYPE      <= mt2_r;
      MODULE_RESTART      <= fw_act && fw_done;
      if (!is_mod)
      begin
        MIDDLE_STATUS_LED <= 1'b0;
        BOTTOM_LINK_LED   <= act_lit[0];
        if (com_err)
          TOP_STATUS_LED <= pulse_on;
        else
          case (st2_r)
            `SLI_ST_PREOP:  TOP_STATUS_LED <= preop_on;
            `SLI_ST_SAFEOP: TOP_STATUS_LED <= safe_on;
            `SLI_ST_BOOT:   TOP_STATUS_LED <= flick_on;
            `SLI_ST_OP:     TOP_STATUS_LED <= pwr_done;
            default:        TOP_STATUS_LED <= 1'b0;
          endcase
      end
      else
        case (ind_r)
          `SLI_IND_ACTIVATE:
          begin
            TOP_STATUS_LED    <= pulse_on && act_led == 2'h0;
            MIDDLE_STATUS_LED <= pulse_on && act_led == 2'h1;
            BOTTOM_LINK_LED   <= pulse_on && act_led == 2'h2;
          end
          `SLI_IND_COMERR:
          begin
            TOP_STATUS_LED    <= pulse_on;
            MIDDLE_STATUS_LED <= 1'b1;
            BOTTOM_LINK_LED   <= 1'b1;
          end
          `SLI_IND_NORMAL:
          begin
            TOP_STATUS_LED    <= 1'b1;
            MIDDLE_STATUS_LED <= 1'b1;
            BOTTOM_LINK_LED   <= 1'b1;
          end
          default:
          begin
            TOP_STATUS_LED    <= pulse_on;
            MIDDLE_STATUS_LED <= pulse_on;
            BOTTOM_LINK_LED   <= pulse_on;
          end
        endcase
    end
  end

endmodule

/* sim/sli_led_viewer.sv */
`timescale 1ns/1ps
// ****
// Operator view: lengths of the lit runs of one LED
// ****
module sli_led_viewer
(
  input  wire clk,
  input  wire clr,
  input  wire led,
  output int  nrun,
  output int  runs [0:7]
);
  int len;
  always @(posedge clk)
  begin
    if (clr)
    begin
      nrun <= 0;
      len <= 0;
    end
    else if (led)
      len <= len + 1;
    else if (len != 0)
    begin
      if (nrun < 8)
        runs[nrun] <= len;
      nrun <= nrun + 1;
      len <= 0;
    end
  end
endmodule

/* sim/sli_status_led_chk.sv */
`timescale 1ns/1ps
`include "sli_defines.vh"
// ****
// Port checker
// ****
module sli_status_led_chk
#(
  parameter POWERUP_MS = 20,
  parameter MS_DIV     = 4,
  parameter TYPE_W     = 8
)
(
  input wire              REF_CLK,
  input wire              RSTN,
  input wire              IS_MODULE,
  input wire [2:0]        BUS_STATE,
  input wire              UP_ACT,
  input wire              DOWN_ACT,
  input wire              LINK_ACT,
  input wire              COMM_ERR,
  input wire              HOT_SWAP_EN,
  input wire              CFG_STORED,
  input wire [TYPE_W-1:0] CFG_TYPE,
  input wire [TYPE_W-1:0] MODULE_TYPE,
  input wire              RECONFIG_DONE,
  input wire              FW_DOWNLOAD,
  input wire              FW_ACTIVATE,
  input wire              FW_RECONF_DONE,
  input wire              UPSTREAM_PORT_LED,
  input wire              DOWNSTREAM_PORT_LED,
  input wire              TOP_STATUS_LED,
  input wire              MIDDLE_STATUS_LED,
  input wire              BOTTOM_LINK_LED,
  input wire              CFG_WRITE,
  input wire [TYPE_W-1:0] CFG_WRITE_TYPE,
  input wire              MODULE_RESTART
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  // The power-up figure is only known in ticks, so the early bound is kept at half of it.
  localparam int PU_EARLY = POWERUP_MS * MS_DIV / 2;
  localparam int PU_LATE  = POWERUP_MS * MS_DIV + 2 * MS_DIV + 8;
  int  up_cnt;
  wire cfg_err = (HOT_SWAP_EN & !CFG_STORED) | (CFG_STORED & (CFG_TYPE != MODULE_TYPE));
  wire op_on   = !IS_MODULE & !COMM_ERR & (BUS_STATE == `SLI_ST_OP);
  wire all_on  = TOP_STATUS_LED & MIDDLE_STATUS_LED & BOTTOM_LINK_LED;
  always @(posedge REF_CLK or negedge RSTN)
    if (!RSTN)
      up_cnt <= 0;
    else if (up_cnt < 1000000)
      up_cnt <= up_cnt + 1;
  sequence s_op_ready;
    (op_on && up_cnt > PU_LATE) [*5];
  endsequence
  sequence s_together;
    (IS_MODULE && !FW_ACTIVATE && (FW_DOWNLOAD || cfg_err)) [*5];
  endsequence
  AST_TOP_WAITS: assert property (op_on && up_cnt < PU_EARLY |-> !TOP_STATUS_LED)
    else $error("top LED lit before power-up ended");
  AST_TOP_STEADY: assert property (s_op_ready |-> TOP_STATUS_LED)
    else $error("top LED not steady in operational state");
  AST_INIT_OFF: assert property
    ((!IS_MODULE && !COMM_ERR && BUS_STATE == `SLI_ST_INIT) [*5] |-> !TOP_STATUS_LED)
    else $error("top LED lit in init state");
  AST_UP_ACT: assert property ($rose(UP_ACT) |-> ##[1:6] UPSTREAM_PORT_LED)
    else $error("upstream LED missed activity");
  AST_DOWN_ACT: assert property ($rose(DOWN_ACT) |-> ##[1:6] DOWNSTREAM_PORT_LED)
    else $error("downstream LED missed activity");
  AST_LINK_ACT: assert property ($rose(LINK_ACT) && !IS_MODULE |-> ##[1:6] BOTTOM_LINK_LED)
    else $error("link LED missed activity");
  AST_MOD_NORMAL: assert property
    ((IS_MODULE && !FW_ACTIVATE && !FW_DOWNLOAD && !cfg_err && !COMM_ERR) [*5] |-> all_on)
    else $error("module LEDs not all on in normal operation");
  AST_TOGETHER: assert property (s_together |-> MIDDLE_STATUS_LED == TOP_STATUS_LED
    && BOTTOM_LINK_LED == TOP_STATUS_LED) else $error("pattern LEDs not in step");
  AST_ONE_AT_A_TIME: assert property ((IS_MODULE && FW_ACTIVATE) [*5]
    |-> $onehot0({TOP_STATUS_LED, MIDDLE_STATUS_LED, BOTTOM_LINK_LED}))
    else $error("more than one LED lit during activation");
  AST_RESTART: assert property ((FW_ACTIVATE && FW_RECONF_DONE) [*4] |-> MODULE_RESTART)
    else $error("restart not requested");
  AST_NO_RESTART: assert property (!FW_ACTIVATE [*4] |-> !MODULE_RESTART)
    else $error("restart without activation");
  AST_CFG_WRITE: assert property ($rose(RECONFIG_DONE)
    |-> ##[1:6] (CFG_WRITE && CFG_WRITE_TYPE == MODULE_TYPE)) else $error("config not written");
endmodule

bind sli_status_led sli_status_led_chk
#(
  .POWERUP_MS (POWERUP_MS),
  .MS_DIV     (MS_DIV),
  .TYPE_W     (TYPE_W)
)
sli_status_led_chk_i
(
  .REF_CLK(REF_CLK), .RSTN(RSTN), .IS_MODULE(IS_MODULE), .BUS_STATE(BUS_STATE),
  .UP_ACT(UP_ACT), .DOWN_ACT(DOWN_ACT), .LINK_ACT(LINK_ACT), .COMM_ERR(COMM_ERR),
  .HOT_SWAP_EN(HOT_SWAP_EN), .CFG_STORED(CFG_STORED), .CFG_TYPE(CFG_TYPE),
  .MODULE_TYPE(MODULE_TYPE), .RECONFIG_DONE(RECONFIG_DONE), .FW_DOWNLOAD(FW_DOWNLOAD),
  .FW_ACTIVATE(FW_ACTIVATE), .FW_RECONF_DONE(FW_RECONF_DONE),
  .UPSTREAM_PORT_LED(UPSTREAM_PORT_LED), .DOWNSTREAM_PORT_LED(DOWNSTREAM_PORT_LED),
  .TOP_STATUS_LED(TOP_STATUS_LED), .MIDDLE_STATUS_LED(MIDDLE_STATUS_LED),
  .BOTTOM_LINK_LED(BOTTOM_LINK_LED), .CFG_WRITE(CFG_WRITE),
  .CFG_WRITE_TYPE(CFG_WRITE_TYPE), .MODULE_RESTART(MODULE_RESTART)
);

/* sim/sli_status_led_bench.sv */
`timescale 1ns/1ps
`include "sli_defines.vh"
// ****
// Bench
// ****
module sli_status_led_bench;
  localparam int PU = 20;
  localparam int MD = 4;
  logic       ref_clk = 0, rstn = 0, is_module = 0, up_act = 0, down_act = 0, link_act = 0;
  logic       comm_err = 0, hot_swap_en = 0, cfg_stored = 0, reconfig_done = 0;
  logic       fw_download = 0, fw_activate = 0, fw_reconf_done = 0;
  logic [2:0] bus_state = `SLI_ST_OP;
  logic [7:0] cfg_type = 8'h00, module_type = 8'h00;
  wire        up_led, down_led, top_led, mid_led, bot_led, cfg_write, module_restart;
  wire  [7:0] cfg_write_type;
  wire  [2:0] lit = {top_led, mid_led, bot_led};
  int         miscompares = 0, total_checks = 0, nrun, runs [0:7], i, k;
  always #25 ref_clk = ~ref_clk;
  sli_status_led #(.POWERUP_MS(PU), .MS_DIV(MD), .TYPE_W(8)) sli_status_led_i (
    .REF_CLK(ref_clk), .RSTN(rstn), .IS_MODULE(is_module), .BUS_STATE(bus_state),
    .UP_ACT(up_act), .DOWN_ACT(down_act), .LINK_ACT(link_act), .COMM_ERR(comm_err),
    .HOT_SWAP_EN(hot_swap_en), .CFG_STORED(cfg_stored), .CFG_TYPE(cfg_type),
    .MODULE_TYPE(module_type), .RECONFIG_DONE(reconfig_done), .FW_DOWNLOAD(fw_download),
    .FW_ACTIVATE(fw_activate), .FW_RECONF_DONE(fw_reconf_done),
    .UPSTREAM_PORT_LED(up_led), .DOWNSTREAM_PORT_LED(down_led), .TOP_STATUS_LED(top_led),
    .MIDDLE_STATUS_LED(mid_led), .BOTTOM_LINK_LED(bot_led), .CFG_WRITE(cfg_write),
    .CFG_WRITE_TYPE(cfg_write_type), .MODULE_RESTART(module_restart));
  sli_led_viewer sli_led_viewer_i (.clk(ref_clk), .clr(!rstn), .led(top_led),
    .nrun(nrun), .runs(runs));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: saw %0h, wanted %0h", $time, seen, exp);
    end
  endtask
  function bit near(input int seen, input int exp);
    return seen >= exp - 8 && seen <= exp + 8;
  endfunction
  task cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task rst;
    rstn = 0;
    cyc(6);
    rstn = 1;
  endtask
  task wait_runs(input int n, input int lim);
    for (k = 0; k < lim && nrun < n; k++)
      cyc(1);
    if (nrun < n)
    begin
      miscompares++;
      $display("unexpected at %0t: LED runs missing", $time);
    end
  endtask
  task wait_lit(input bit on);
    for (k = 0; k < 4000 && ((lit != 0) != on); k++)
      cyc(1);
    if ((lit != 0) != on)
    begin
      miscompares++;
      $display("unexpected at %0t: LED level never reached", $time);
    end
  endtask
  task t_powerup;
    rst;
    cyc(PU * MD / 2);
    chk(top_led, 0);
    cyc(PU * MD + 20);
    chk(top_led, 1);
    bus_state = `SLI_ST_INIT;
    cyc(8);
    chk(top_led, 0);
  endtask
  task t_states;
    logic [2:0] st [3] = '{`SLI_ST_PREOP, `SLI_ST_SAFEOP, `SLI_ST_BOOT};
    int hi [3] = '{`SLI_PREOP_MS / 2 * MD, `SLI_SAFEOP_MS / 2 * MD, `SLI_FLICKER_MS / 2 * MD};
    for (i = 0; i < 3; i++)
    begin
      bus_state = st[i];
      rst;
      wait_runs(2, 30000);
      chk(near(runs[1], hi[i]), 1);
    end
  endtask
  task t_activity;
    bus_state = `SLI_ST_INIT;
    for (i = 0; i < 3; i++)
    begin
      {up_act, down_act, link_act} = 3'b100 >> i;
      cyc(1);
      {up_act, down_act, link_act} = 3'h0;
      cyc(6);
      chk({up_led, down_led, bot_led}, 3'b100 >> i);
      cyc(50 * MD + 10);
      chk({up_led, down_led, bot_led}, 3'h0);
    end
  endtask
  task t_normal;
    is_module = 1;
    {cfg_stored, hot_swap_en, cfg_type, module_type} = {2'h3, 8'h3C, 8'h3C};
    rst;
    cyc(400);
    chk(lit, 3'h7);
  endtask
  task t_sos;
    for (i = 0; i < 2; i++)
    begin
      {cfg_stored, hot_swap_en, module_type} = (i == 0) ? {2'h1, 8'h3C} : {2'h2, 8'hC3};
      rst;
      wait_runs(4, 10000);
      chk(near(runs[0], 200 * MD), 1);
      chk(near(runs[3], 600 * MD), 1);
    end
  endtask
  task t_reconfig;
    module_type = 8'h5A;
    reconfig_done = 1;
    cyc(1);
    reconfig_done = 0;
    for (k = 0; k < 10 && cfg_write !== 1'b1; k++)
      cyc(1);
    chk(cfg_write, 1);
    chk(cfg_write_type, 8'h5A);
    // The socket memory now holds what was written, as on the next power-up.
    cfg_type = 8'h5A;
    rst;
    cyc(8);
    chk(lit, 3'h7);
  endtask
  task t_download;
    {fw_download, hot_swap_en, cfg_stored} = 3'h6;
    rst;
    wait_runs(2, 6000);
    chk(near(runs[0], 200 * MD), 1);
    chk(near(runs[1], 600 * MD), 1);
  endtask
  task t_activate;
    logic [2:0] want [3] = '{3'h4, 3'h2, 3'h1};
    fw_activate = 1;
    rst;
    // The registered indication lags the synchronised role input by one cycle after reset, so let it settle first.
    cyc(4);
    for (i = 0; i < 3; i++)
    begin
      wait_lit(1);
      chk(lit, want[i]);
      wait_lit(0);
    end
    fw_reconf_done = 1;
    cyc(6);
    chk(module_restart, 1);
    {fw_activate, fw_download, fw_reconf_done, hot_swap_en} = 4'h0;
  endtask
  task t_comm;
    comm_err = 1;
    for (i = 0; i < 2; i++)
    begin
      is_module = (i == 0);
      rst;
      wait_runs(2, 4000);
      chk(runs[1] >= 40 * MD && runs[1] <= 100 * MD + 4, 1);
      chk(runs[0] != runs[1], 1);
      chk({mid_led, bot_led}, (i == 0) ? 2'h3 : 2'h0);
    end
  endtask
  task finish_test;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    // The scenarios need about 50,000 cycles; this limit leaves margin and stays under the cap.
    repeat (80000) @(posedge ref_clk);
    miscompares++;
    finish_test;
  end
  initial
  begin
    t_powerup;
    t_states;
    t_activity;
    t_normal;
    t_sos;
    t_reconfig;
    t_download;
    t_activate;
    t_comm;
    finish_test;
  end
endmodule
